// [mst_table_unit.sv]
// top of the microstep wave-table unit: APB registers, fine step counter,
// three table pointers over a user RAM and the per-channel DAC values.
// assumes step_pulse/step_forward come from the step source, synchronous to pclk.
//
// The APB register port was chosen for this implementation.

// Contract
// - RAM holds 128 entries of 8 bits, loadable by the host.
// - table holds one half wave, at most 64 microsteps per fullstep.
// - three independent 7-bit pointers, one per DAC channel.
// - every motor step in microstep mode moves each pointer by one.
// - data register writes store at, and reads return, the selected location.
// - pointers wrap with modulus table-end plus one.
// - byte under each pointer is its channel's output value.
// - fullstep distance register holds microsteps minus one per fullstep.
// - counter underflow or passing distance gives one fullstep clock.
// - unsplit: all pointers share one table from location zero.
// - split: three areas of table-end plus one, each pointer in its own.
// - microsteps are generated only while phase generation is enabled.
// - each fullstep advances the sequencer to its next pattern.
// - phase generation enable is config bit 9, cleared at reset.
// - step-type field value binary 10 selects microstep operation.
// - each channel shows its pointer's byte; third only for three-phase.
module mst_table_unit #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  input  wire logic        pclk,           // APB clock, 250 MHz
  input  wire logic        presetn,        // async reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB access phase
  input  wire logic        pwrite,         // APB direction
  input  wire logic [11:0] paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready, always high
  output logic             pslverr,        // unmapped access
  input  wire logic        step_pulse,     // one-cycle motor step
  input  wire logic        step_forward,   // step direction, high = forward
  output logic             fullstep_pulse, // clocks the phase sequencer
  output logic             fullstep_forward, // direction of that fullstep
  output logic [7:0]       dac0_value,     // channel 0 converter value
  output logic [7:0]       dac1_value,     // channel 1 converter value
  output logic [7:0]       dac2_value      // channel 2 converter value
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  // the 7-bit register map and pointer logic serve only this shape
  if (ADDR_W != 7 || DATA_W != 8) begin : g_bad_shape
    $error("mst_table_unit supports only a 128 x 8 RAM");
  end

  // ************************************************************
  // register state
  // ************************************************************
  logic [6:0]  wave_ram_address;
  logic [6:0]  wave_table_last;
  logic [6:0]  coarse_step_interval;
  logic [6:0]  fine_step_counter;
  logic        wave_table_layout;
  logic [11:0] sequencer_config;
  logic [6:0]  channel0_pointer;
  logic [6:0]  channel1_pointer;
  logic [6:0]  channel2_pointer;
  logic [7:0]  host_q;
  logic [7:0]  chan_q0;
  logic [7:0]  chan_q1;
  logic [7:0]  chan_q2;

  // ************************************************************
  // bus decode
  // ************************************************************
  logic        access;
  logic        wr_fire;
  logic [7:0]  reg_idx;
  logic        mapped;

  assign access  = psel & penable;
  assign wr_fire = access & pwrite & mapped;
  assign reg_idx = paddr[9:2];
  assign pready  = 1'b1; // every register answers without wait states

  // which word indices exist; low address bits and upper bits must be clear
  always_comb begin
    mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    case (reg_idx)
      mst_pkg::IDX_WAVE_RAM_ADDRESS,
      mst_pkg::IDX_WAVE_RAM_VALUE,
      mst_pkg::IDX_WAVE_TABLE_LAST,
      mst_pkg::IDX_CHANNEL0_POINTER,
      mst_pkg::IDX_CHANNEL1_POINTER,
      mst_pkg::IDX_CHANNEL2_POINTER,
      mst_pkg::IDX_COARSE_STEP_INTERVAL,
      mst_pkg::IDX_FINE_STEP_COUNTER,
      mst_pkg::IDX_WAVE_TABLE_LAYOUT,
      mst_pkg::IDX_SEQUENCER_CONFIG: mapped = mapped;
      default:                       mapped = 1'b0;
    endcase
  end

  assign pslverr = access & ~mapped;

  function automatic logic wr_hit(input logic fire, input logic [7:0] idx,
                                  input logic [7:0] target);
    wr_hit = fire && (idx == target);
  endfunction : wr_hit

  // ************************************************************
  // mode decode
  // ************************************************************
  logic       phase_generation_enable;
  logic       micro_mode;
  logic       three_phase;
  logic       step_go;

  assign phase_generation_enable = sequencer_config[mst_pkg::POS_PHASE_GENERATION_ENABLE];
  assign micro_mode  = phase_generation_enable &&
                       (sequencer_config[mst_pkg::POS_STEP_TYPE_LO +: 2] == mst_pkg::STEP_TYPE_MICRO);
  assign three_phase = (sequencer_config[mst_pkg::POS_MOTOR_TYPE_LO +: 2] == mst_pkg::MOTOR_TYPE_THREE);
  // steps outside microstep generation leave the table untouched
  assign step_go     = step_pulse & micro_mode;

  // ************************************************************
  // configuration registers
  // ************************************************************
  // the address register holds still across data accesses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_ram_address <= mst_pkg::RST_PTR7;
    end else if (wr_hit(wr_fire, reg_idx, mst_pkg::IDX_WAVE_RAM_ADDRESS)) begin
      wave_ram_address <= pwdata[6:0];
    end
  end

  // table geometry; software keeps these still while generation runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_table_last   <= mst_pkg::RST_PTR7;
      wave_table_layout <= 1'b0;
    end else begin
      if (wr_hit(wr_fire, reg_idx, mst_pkg::IDX_WAVE_TABLE_LAST)) begin
        wave_table_last <= pwdata[6:0];
      end
      if (wr_hit(wr_fire, reg_idx, mst_pkg::IDX_WAVE_TABLE_LAYOUT)) begin
        wave_table_layout <= pwdata[mst_pkg::POS_LAYOUT_SPLIT];
      end
    end
  end

  // fullstep distance and sequencer configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coarse_step_interval <= mst_pkg::RST_PTR7;
      sequencer_config     <= mst_pkg::RST_SEQ_CFG;
    end else begin
      if (wr_hit(wr_fire, reg_idx, mst_pkg::IDX_COARSE_STEP_INTERVAL)) begin
        coarse_step_interval <= pwdata[6:0];
      end
      if (wr_hit(wr_fire, reg_idx, mst_pkg::IDX_SEQUENCER_CONFIG)) begin
        sequencer_config <= pwdata[11:0] & mst_pkg::SEQ_CONFIG_MASK;
      end
    end
  end

  // ************************************************************
  // fine step counter and fullstep clock
  // ************************************************************
  // forward: pass the distance and restart at zero; reverse: underflow to it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fine_step_counter <= mst_pkg::RST_PTR7;
      fullstep_pulse    <= 1'b0;
      fullstep_forward  <= 1'b0;
    end else begin
      fullstep_pulse <= 1'b0;
      if (wr_hit(wr_fire, reg_idx, mst_pkg::IDX_FINE_STEP_COUNTER)) begin
        fine_step_counter <= pwdata[6:0];
      end else if (step_go) begin
        if (step_forward) begin
          if (fine_step_counter >= coarse_step_interval) begin
            fine_step_counter <= 7'h00;
            fullstep_pulse    <= 1'b1;
            fullstep_forward  <= 1'b1;
          end else begin
            fine_step_counter <= 7'(fine_step_counter + 7'h01);
          end
        end else begin
          if (fine_step_counter == 7'h00) begin
            fine_step_counter <= coarse_step_interval;
            fullstep_pulse    <= 1'b1;
            fullstep_forward  <= 1'b0;
          end else begin
            fine_step_counter <= 7'(fine_step_counter - 7'h01);
          end
        end
      end
    end
  end

  // ************************************************************
  // table pointers
  // ************************************************************
  mst_step_if stp ();

  assign stp.step    = step_go;
  assign stp.forward = step_forward;
  assign stp.last    = wave_table_last;
  assign stp.split   = wave_table_layout;
  assign stp.wdata   = pwdata[6:0];

  mst_pointer #(.CHAN(2'h0)) u_ptr0 (
    .pclk    (pclk),
    .presetn (presetn),
    .stp     (stp),
    .load    (wr_hit(wr_fire, reg_idx, mst_pkg::IDX_CHANNEL0_POINTER)),
    .pointer (channel0_pointer)
  );

  mst_pointer #(.CHAN(2'h1)) u_ptr1 (
    .pclk    (pclk),
    .presetn (presetn),
    .stp     (stp),
    .load    (wr_hit(wr_fire, reg_idx, mst_pkg::IDX_CHANNEL1_POINTER)),
    .pointer (channel1_pointer)
  );

  mst_pointer #(.CHAN(2'h2)) u_ptr2 (
    .pclk    (pclk),
    .presetn (presetn),
    .stp     (stp),
    .load    (wr_hit(wr_fire, reg_idx, mst_pkg::IDX_CHANNEL2_POINTER)),
    .pointer (channel2_pointer)
  );

  // ************************************************************
  // waveform RAM
  // ************************************************************
  // writes are accepted at any time; only the geometry must be held still
  mst_wave_ram #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_ram (
    .pclk   (pclk),
    .we     (wr_hit(wr_fire, reg_idx, mst_pkg::IDX_WAVE_RAM_VALUE)),
    .waddr  (wave_ram_address),
    .wdata  (pwdata[7:0]),
    .raddr0 (wave_ram_address),
    .raddr1 (channel0_pointer),
    .raddr2 (channel1_pointer),
    .raddr3 (channel2_pointer),
    .q0     (host_q),
    .q1     (chan_q0),
    .q2     (chan_q1),
    .q3     (chan_q2)
  );

  // ************************************************************
  // converter values
  // ************************************************************
  // outside microstep mode the table drives nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac0_value <= mst_pkg::RST_BYTE;
      dac1_value <= mst_pkg::RST_BYTE;
      dac2_value <= mst_pkg::RST_BYTE;
    end else begin
      dac0_value <= micro_mode ? chan_q0 : mst_pkg::RST_BYTE;
      dac1_value <= micro_mode ? chan_q1 : mst_pkg::RST_BYTE;
      dac2_value <= (micro_mode && three_phase) ? chan_q2 : mst_pkg::RST_BYTE;
    end
  end

  // ************************************************************
  // read mux
  // ************************************************************
  // the address register is write-only and reads as zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (access && !pwrite && mapped) begin
      case (reg_idx)
        mst_pkg::IDX_WAVE_RAM_VALUE:       prdata = {24'h000000, host_q};
        mst_pkg::IDX_WAVE_TABLE_LAST:      prdata = {25'h0, wave_table_last};
        mst_pkg::IDX_CHANNEL0_POINTER:     prdata = {25'h0, channel0_pointer};
        mst_pkg::IDX_CHANNEL1_POINTER:     prdata = {25'h0, channel1_pointer};
        mst_pkg::IDX_CHANNEL2_POINTER:     prdata = {25'h0, channel2_pointer};
        mst_pkg::IDX_COARSE_STEP_INTERVAL: prdata = {25'h0, coarse_step_interval};
        mst_pkg::IDX_FINE_STEP_COUNTER:    prdata = {25'h0, fine_step_counter};
        mst_pkg::IDX_WAVE_TABLE_LAYOUT:    prdata = {30'h0, wave_table_layout, 1'b0};
        mst_pkg::IDX_SEQUENCER_CONFIG:     prdata = {20'h0, sequencer_config};
        default:                           prdata = 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  logic [6:0] split_top1;
  assign split_top1 = 7'({wave_table_last, 1'b0} + 8'h01);

  sequence s_fwd_wrap;
    step_go && step_forward && !wr_fire && (fine_step_counter >= coarse_step_interval);
  endsequence

  sequence s_rev_under;
    step_go && !step_forward && !wr_fire && (fine_step_counter == 7'h00);
  endsequence

  property p_fullstep_forward;
    @(posedge pclk) disable iff (!presetn)
      s_fwd_wrap |=> fullstep_pulse && fullstep_forward && (fine_step_counter == 7'h00);
  endproperty
  a_fullstep_forward: assert property (p_fullstep_forward) else $error("forward fullstep missing");

  property p_fullstep_under;
    @(posedge pclk) disable iff (!presetn)
      s_rev_under |=> fullstep_pulse && !fullstep_forward
                      && (fine_step_counter == $past(coarse_step_interval));
  endproperty
  a_fullstep_under: assert property (p_fullstep_under) else $error("underflow fullstep missing");

  property p_no_step_when_off;
    @(posedge pclk) disable iff (!presetn)
      !phase_generation_enable ##1 !phase_generation_enable |-> !fullstep_pulse;
  endproperty
  a_no_step_when_off: assert property (p_no_step_when_off) else $error("fullstep while disabled");

  property p_ptr0_wrap;
    @(posedge pclk) disable iff (!presetn)
      step_go && step_forward && !wave_table_layout && (channel0_pointer == wave_table_last)
      && !wr_fire |=> channel0_pointer == 7'h00;
  endproperty
  a_ptr0_wrap: assert property (p_ptr0_wrap) else $error("pointer 0 did not wrap");

  property p_ptr0_incr;
    @(posedge pclk) disable iff (!presetn)
      step_go && step_forward && !wave_table_layout && (channel0_pointer < wave_table_last)
      && !wr_fire |=> channel0_pointer == 7'($past(channel0_pointer) + 7'h01);
  endproperty
  a_ptr0_incr: assert property (p_ptr0_incr) else $error("pointer 0 did not advance");

  property p_ptr1_rev_split;
    @(posedge pclk) disable iff (!presetn)
      step_go && !step_forward && wave_table_layout
      && (channel1_pointer == 7'(wave_table_last + 7'h01)) && !wr_fire
      |=> channel1_pointer == $past(split_top1);
  endproperty
  a_ptr1_rev_split: assert property (p_ptr1_rev_split) else $error("pointer 1 left its area");

  property p_ram_roundtrip;
    @(posedge pclk) disable iff (!presetn)
      wr_hit(wr_fire, reg_idx, mst_pkg::IDX_WAVE_RAM_VALUE) |-> ##2 host_q == $past(pwdata[7:0], 2);
  endproperty
  a_ram_roundtrip: assert property (p_ram_roundtrip) else $error("RAM readback mismatch");

  property p_dac2_gate;
    @(posedge pclk) disable iff (!presetn)
      !(micro_mode && three_phase) |=> dac2_value == 8'h00;
  endproperty
  a_dac2_gate: assert property (p_dac2_gate) else $error("channel 2 driven outside three-phase");

  property p_dac0_follow;
    @(posedge pclk) disable iff (!presetn)
      micro_mode |=> dac0_value == $past(chan_q0);
  endproperty
  a_dac0_follow: assert property (p_dac0_follow) else $error("channel 0 value not from table");

endmodule : mst_table_unit

// [mst_pkg.sv]
// package for the microstep wave-table unit: register indices, field layout,
// reset values and shared address arithmetic.
// assumes a 32-bit APB slave with one aligned word per register index.
package mst_pkg;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_WAVE_RAM_ADDRESS      = 8'hE0;
  localparam logic [7:0] IDX_WAVE_RAM_VALUE        = 8'hE1;
  localparam logic [7:0] IDX_WAVE_TABLE_LAST       = 8'hE4;
  localparam logic [7:0] IDX_CHANNEL0_POINTER      = 8'hE5;
  localparam logic [7:0] IDX_CHANNEL1_POINTER      = 8'hE6;
  localparam logic [7:0] IDX_CHANNEL2_POINTER      = 8'hE7;
  localparam logic [7:0] IDX_COARSE_STEP_INTERVAL  = 8'hE8;
  localparam logic [7:0] IDX_FINE_STEP_COUNTER     = 8'hE9;
  localparam logic [7:0] IDX_WAVE_TABLE_LAYOUT     = 8'hEA;
  localparam logic [7:0] IDX_SEQUENCER_CONFIG      = 8'hF0;

  // ************************************************************
  // field layout
  // ************************************************************
  localparam int         POS_LAYOUT_SPLIT   = 1;   // table split bit
  localparam int         POS_MOTOR_TYPE_LO  = 0;   // 2-bit motor type
  localparam int         POS_STEP_TYPE_LO   = 2;   // 2-bit step type
  localparam int         POS_PHASE_GENERATION_ENABLE   = 9;   // phase generation enable
  localparam logic [1:0] STEP_TYPE_MICRO    = 2'h2;
  localparam logic [1:0] MOTOR_TYPE_THREE   = 2'h1;
  localparam logic [11:0] SEQ_CONFIG_MASK   = 12'h20F;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [6:0]  RST_PTR7    = 7'h00;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [11:0] RST_SEQ_CFG = 12'h000;

  // first location of a channel's area; every channel starts at zero unsplit
  function automatic logic [6:0] mst_area_base(input logic [1:0] chan,
                                               input logic [6:0] last,
                                               input logic       split);
    logic [8:0] span;
    span = {2'h0, last} + 9'h001;
    if (!split) begin
      mst_area_base = 7'h00;
    end else begin
      mst_area_base = 7'(span * {7'h00, chan});
    end
  endfunction : mst_area_base

endpackage : mst_pkg

// [mst_step_if.sv]
// interface carrying the step event and table geometry to the pointers.
// assumes one clock domain; the source drives, each pointer only listens.
interface mst_step_if;
  logic       step;     // one-cycle pulse: a step is taken now
  logic       forward;  // step direction, high = forward
  logic [6:0] last;     // table-end value
  logic       split;    // three-area layout selected
  logic [6:0] wdata;    // host write value for a pointer load

  modport src (output step, output forward, output last, output split, output wdata);
  modport ptr (input step, input forward, input last, input split, input wdata);
endinterface : mst_step_if

// [mst_pointer.sv]
// one table pointer of the microstep unit, cycling inside its own area.
// assumes the host load strobe and step pulse are synchronous to pclk.
module mst_pointer #(
  parameter logic [1:0] CHAN = 2'h0
) (
  input  wire logic    pclk,      // system clock
  input  wire logic    presetn,   // async reset, active low
  mst_step_if.ptr      stp,       // step event and geometry
  input  wire logic    load,      // host write to this pointer
  output logic [6:0]   pointer    // current RAM location
);

  // next location one step away, wrapping at the area's ends
  function automatic logic [6:0] step_next(input logic [6:0] cur,
                                           input logic       fwd,
                                           input logic [6:0] base,
                                           input logic [6:0] last);
    logic [6:0] top;
    top = 7'(base + last);
    if (fwd) begin
      step_next = (cur == top) ? base : 7'(cur + 7'h01);
    end else begin
      step_next = (cur == base) ? top : 7'(cur - 7'h01);
    end
  endfunction : step_next

  // ************************************************************
  // pointer register
  // ************************************************************
  // host load wins so that a preset start position is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pointer <= mst_pkg::RST_PTR7;
    end else if (load) begin
      pointer <= stp.wdata;
    end else if (stp.step) begin
      pointer <= step_next(pointer, stp.forward,
                           mst_pkg::mst_area_base(CHAN, stp.last, stp.split),
                           stp.last);
    end
  end

endmodule : mst_pointer

// [mst_wave_ram.sv]
// waveform RAM: one write port and four registered read ports.
// assumes addresses and write strobe are synchronous to pclk.
module mst_wave_ram #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  input  wire logic              pclk,     // system clock
  input  wire logic              we,       // write strobe
  input  wire logic [ADDR_W-1:0] waddr,    // write location
  input  wire logic [DATA_W-1:0] wdata,    // write value
  input  wire logic [ADDR_W-1:0] raddr0,   // host read location
  input  wire logic [ADDR_W-1:0] raddr1,   // channel 0 location
  input  wire logic [ADDR_W-1:0] raddr2,   // channel 1 location
  input  wire logic [ADDR_W-1:0] raddr3,   // channel 2 location
  output logic      [DATA_W-1:0] q0,       // host read value
  output logic      [DATA_W-1:0] q1,       // channel 0 value
  output logic      [DATA_W-1:0] q2,       // channel 1 value
  output logic      [DATA_W-1:0] q3        // channel 2 value
);

  // contents are left undefined at reset; software loads them
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // write port
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered reads give clean flop outputs toward the converters
  always_ff @(posedge pclk) begin
    q0 <= mem[raddr0];
    q1 <= mem[raddr1];
    q2 <= mem[raddr2];
    q3 <= mem[raddr3];
  end

endmodule : mst_wave_ram

// [mst_step_model.sv]
// step source and fullstep sequencer stand-in for the wave-table unit.
// assumes calls to step come right after a rising edge of pclk.
module mst_step_model (
  input  wire logic pclk,           // system clock
  input  wire logic fullstep_pulse, // sequencer clock from the unit
  output logic      step_pulse,     // one-cycle motor step
  output logic      step_forward,   // step direction
  output int        fulls           // sequencer clocks seen
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    step_pulse = 1'b0;
    step_forward = 1'b1;
    fulls = 0;
  end
  // each counted pulse moves the sequencer to its next pattern
  always @(posedge pclk) begin
    if (fullstep_pulse === 1'b1) fulls <= fulls + 1;
  end
  // three spare edges let the dac output flops settle
  task automatic step(input logic fwd);
    step_pulse <= 1'b1;
    step_forward <= fwd;
    @(posedge pclk);
    step_pulse <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : step
endmodule : mst_step_model

// [testbench.sv]
// self-checking bench: apb register tasks and step sequences.
// assumes zero-wait apb slave; word index times four is the byte address.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic pready, pslverr, e, fp, ff, sp, sf;
  logic [7:0] dac0, dac1, dac2;
  int mismatches = 0, checks = 0, fulls;
  initial forever #2 pclk = ~pclk;
  mst_table_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .step_pulse(sp),
    .step_forward(sf), .fullstep_pulse(fp), .fullstep_forward(ff), .dac0_value(dac0), .dac1_value(dac1),
    .dac2_value(dac2));
  mst_step_model src (.pclk(pclk), .fullstep_pulse(fp), .step_pulse(sp), .step_forward(sf), .fulls(fulls));
  // one apb transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd);
  endtask : wr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(d, exp);
  endtask : rc
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
  initial begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(8'hF0, 32'h0);
    chk({31'h0, pready}, 32'h1);
    xfer(1'b0, 8'h10, 32'h0);
    chk({31'h0, e}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      wr(8'hE0, i);
      wr(8'hE1, 32'h10 + i);
    end
    for (int i = 0; i < 6; i++) begin
      wr(8'hE0, i);
      rc(8'hE1, 32'h10 + i);
      rc(8'hE1, 32'h10 + i);
    end
    $display("test ram done");
    wr(8'hE4, 3); wr(8'hE8, 1); wr(8'hE5, 0); wr(8'hE6, 1); wr(8'hE7, 2);
    wr(8'hF0, 32'h209);
    for (int k = 1; k < 6; k++) begin
      src.step(1'b1);
      chk({24'h0, dac0}, 32'h10 + 32'(k % 4));
      chk({24'h0, dac1}, 32'h10 + 32'((k + 1) % 4));
      chk({24'h0, dac2}, 32'h10 + 32'((k + 2) % 4));
      rc(8'hE5, k % 4);
      rc(8'hE6, (k + 1) % 4);
    end
    chk(fulls, 2);
    chk({31'h0, ff}, 32'h1);
    rc(8'hE9, 1);
    src.step(1'b0);
    src.step(1'b0);
    rc(8'hE5, 3);
    chk(fulls, 3);
    chk({31'h0, ff}, 32'h0);
    $display("test steps done");
    wr(8'hF0, 32'h8);
    src.step(1'b1);
    rc(8'hE5, 3);
    chk({24'h0, dac0}, 32'h0);
    wr(8'hEA, 2); wr(8'hE4, 1); wr(8'hE5, 1); wr(8'hE6, 3); wr(8'hE7, 5);
    wr(8'hF0, 32'h209);
    src.step(1'b1);
    rc(8'hE5, 0);
    rc(8'hE6, 2);
    rc(8'hE7, 4);
    src.step(1'b0);
    rc(8'hE6, 3);
    wr(8'hF0, 32'h8);
    wr(8'hE4, 63);
    wr(8'hE5, 1);
    wr(8'hE6, 64);
    wr(8'hF0, 32'h208);
    src.step(1'b0);
    rc(8'hE6, 32'h7F);
    chk({24'h0, dac2}, 32'h0);
    wr(8'hE0, 6);
    wr(8'hE1, 32'h55);
    wr(8'hE1, 32'h55);
    rc(8'hE1, 32'h55);
    $display("test split done");
    summarize();
  end
endmodule : testbench
